// [hw/fec_ctrl.sv]
// Purpose: Host controller driving an asynchronous NOR flash command set
// Assumes: Flash pins synchronous to clk_i; software on classic Wishbone
// Notes: Status byte of the last poll is kept for software to inspect
//
// Overview of operation
// R1 - Device status bit 7 reads 1 when ready, 0 when busy.
// R2 - Extended status bit 7 reads 1 when a write buffer is free.
// R3 - Device error flags stay latched until the clear-status code is written.
// R4 - Clear status is issued only while device is idle or suspended.
// R5 - Block erase is a setup write then a confirm inside the block.
// R6 - Status is refreshed by toggling output enable between reads.
// R7 - A malformed erase sequence sets program-error and erase-error.
// R8 - Erase at low voltage or on a locked block sets error flags.
// R9 - After erase or program the device stays in status-read mode.
// R10 - After suspend, ready then erase-suspended flags rise.
// R11 - While suspended, reads and other-block programs are allowed.
// R12 - While suspended, only a limited command set is accepted.
// R13 - Resume clears flags; never resume before a suspended program ends.
// R14 - Repeat buffer setup until the buffer-available bit reads 1.
// R15 - Send count, then start address; later addresses stay in range.
// R16 - Buffer start address should have its five low bits zero; the code accepts any start and only sets unaligned.
// R17 - After last buffer word a confirm starts programming.
// R18 - Program failure sets program-error; buffer writes refused on error.
// R19 - Buffer write across an erase block aborts with both errors.
// R20 - Buffer write at low voltage or locked block sets error flags.
// R21 - Single program: setup code, then address and data write.
// R22 - Single program at low voltage or locked block sets error flags.
`timescale 1ns/10ps
`include "fec_consts.svh"

module fec_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Flash pins
    output logic [23:0] flash_addr_o,
    output logic [15:0] flash_dq_o,
    output logic flash_dq_oe_n_o,
    input wire logic [15:0] flash_dq_i,
    output logic chip_enable_x_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    input wire logic ready_status_pin_i
);

    localparam logic [3:0] SETUP_CYC = 4'(`FEC_CYC(`FEC_SETUP_NS));
    localparam logic [3:0] WE_CYC = 4'(`FEC_CYC(`FEC_WE_NS));
    localparam logic [3:0] ACC_CYC = 4'(`FEC_CYC(`FEC_ACC_NS));

    fec_pkg::fec_main_t state;
    fec_pkg::fec_bus_t bstate;
    fec_pkg::fec_op_t op;
    logic [23:0] addr_reg;
    logic [15:0] data_reg;
    logic [7:0] count_reg;
    logic [7:0] stat_byte;
    logic [7:0] extended_buffer_status;
    logic [23:0] buf_start;
    logic buf_open;
    logic range_err;
    logic unaligned;
    logic ready_seen;
    logic req;
    logic req_rd;
    logic [23:0] req_addr;
    logic [15:0] req_data;
    logic bdone;
    logic [3:0] bcnt;
    logic [15:0] rd_data;
    logic wb_req;
    logic busy;
    logic in_range;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busy = (state != fec_pkg::M_IDLE);
    assign in_range = (addr_reg >= buf_start)
        && ((addr_reg - buf_start) <= {16'h0000, count_reg});

    // Wishbone answer one cycle after the request; unmapped reads give 0
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    5'(`FEC_REG_CTRL): wb_dat_o <= {31'h0, busy};
                    5'(`FEC_REG_ADDR): wb_dat_o <= {8'h00, addr_reg};
                    5'(`FEC_REG_DATA): wb_dat_o <= {16'h0000, data_reg};
                    5'(`FEC_REG_COUNT): wb_dat_o <= {24'h0, count_reg};
                    `FEC_REG_STAT: wb_dat_o <= {12'h0, ready_seen,
                        unaligned, range_err, busy, extended_buffer_status,
                        stat_byte};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    // Parameter registers; writes are ignored while an operation runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= 24'h0;
            data_reg <= 16'h0;
            count_reg <= 8'h0;
        end else if (wb_req && wb_we_i && !busy) begin
            if (wb_adr_i == 5'(`FEC_REG_ADDR) && wb_sel_i[0])
                addr_reg <= wb_dat_i[23:0];
            if (wb_adr_i == 5'(`FEC_REG_DATA) && wb_sel_i[0])
                data_reg <= wb_dat_i[15:0];
            if (wb_adr_i == 5'(`FEC_REG_COUNT) && wb_sel_i[0])
                count_reg <= wb_dat_i[7:0];
        end
    end

    // Flash bus cycle engine; strobes are never low together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bstate <= fec_pkg::B_IDLE;
            bcnt <= 4'h0;
            bdone <= 1'b0;
            rd_data <= 16'h0;
            flash_addr_o <= 24'h0;
            flash_dq_o <= 16'h0;
            flash_dq_oe_n_o <= 1'b1;
            chip_enable_x_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
        end else begin
            bdone <= 1'b0;
            unique case (bstate)
                fec_pkg::B_IDLE: begin
                    if (req && !bdone) begin
                        flash_addr_o <= req_addr;
                        flash_dq_o <= req_data;
                        flash_dq_oe_n_o <= req_rd;
                        chip_enable_x_n_o <= 1'b0;
                        bcnt <= SETUP_CYC;
                        bstate <= fec_pkg::B_SETUP;
                    end
                end
                fec_pkg::B_SETUP: begin
                    if (bcnt > 4'h1) begin
                        bcnt <= bcnt - 4'h1;
                    end else begin
                        // Fresh OE edge on every read refreshes status [R6]
                        oe_n_o <= !req_rd;
                        we_n_o <= req_rd;
                        bcnt <= req_rd ? ACC_CYC : WE_CYC;
                        bstate <= fec_pkg::B_STROBE;
                    end
                end
                fec_pkg::B_STROBE: begin
                    if (bcnt > 4'h1) begin
                        bcnt <= bcnt - 4'h1;
                    end else begin
                        // Data is latched by the device on WE rising [R21]
                        rd_data <= flash_dq_i;
                        oe_n_o <= 1'b1;
                        we_n_o <= 1'b1;
                        bstate <= fec_pkg::B_HOLD;
                    end
                end
                fec_pkg::B_HOLD: begin
                    chip_enable_x_n_o <= 1'b1;
                    flash_dq_oe_n_o <= 1'b1;
                    bdone <= 1'b1;
                    bstate <= fec_pkg::B_IDLE;
                end
            endcase
        end
    end

    // Operation sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= fec_pkg::M_IDLE;
            op <= fec_pkg::OP_NONE;
            req <= 1'b0;
            req_rd <= 1'b0;
            req_addr <= 24'h0;
            req_data <= 16'h0;
            stat_byte <= 8'h0;
            extended_buffer_status <= 8'h0;
            buf_start <= 24'h0;
            buf_open <= 1'b0;
            range_err <= 1'b0;
            unaligned <= 1'b0;
            ready_seen <= 1'b0;
        end else begin
            ready_seen <= ready_status_pin_i;
            if (bdone)
                req <= 1'b0;
            unique case (state)
                fec_pkg::M_IDLE: begin
                    if (wb_req && wb_we_i && wb_adr_i == 5'(`FEC_REG_CTRL)
                        && wb_sel_i[0]) begin
                        op <= fec_pkg::fec_op_t'(wb_dat_i[3:0]);
                        unique case (fec_pkg::fec_op_t'(wb_dat_i[3:0]))
                            // Clear and resume wait for a ready device [R4][R13]
                            fec_pkg::OP_CLEAR, fec_pkg::OP_RESUME,
                            fec_pkg::OP_WAIT:
                                state <= fec_pkg::M_RSC;
                            fec_pkg::OP_BUF_DATA: begin
                                // Out-of-window data is refused [R15]
                                if (buf_open && !in_range) begin
                                    range_err <= 1'b1;
                                end else begin
                                    state <= fec_pkg::M_W1;
                                end
                            end
                            fec_pkg::OP_NONE: state <= fec_pkg::M_IDLE;
                            default: state <= fec_pkg::M_W1;
                        endcase
                    end
                end
                fec_pkg::M_RSC: begin
                    // Read-status command puts device in status mode [R9]
                    req <= !bdone;
                    req_rd <= 1'b0;
                    req_data <= `FEC_CMD_RDSTAT;
                    if (bdone)
                        state <= fec_pkg::M_POLL;
                end
                fec_pkg::M_POLL: begin
                    req <= !bdone;
                    req_rd <= 1'b1;
                    if (bdone) begin
                        stat_byte <= rd_data[7:0];
                        // Poll until the ready flag is 1 [R1]
                        if (rd_data[`FEC_SR_READY])
                            state <= (op == fec_pkg::OP_WAIT)
                                ? fec_pkg::M_DONE : fec_pkg::M_W1;
                    end
                end
                fec_pkg::M_W1: begin
                    req <= !bdone;
                    req_rd <= 1'b0;
                    req_addr <= addr_reg;
                    unique case (op)
                        fec_pkg::OP_CLEAR: req_data <= `FEC_CMD_CLEAR; // [R3]
                        fec_pkg::OP_ERASE: req_data <= `FEC_CMD_ERASE; // [R5]
                        fec_pkg::OP_SUSPEND: req_data <= `FEC_CMD_SUSPEND;
                        fec_pkg::OP_RESUME: req_data <= `FEC_CMD_RESUME;
                        fec_pkg::OP_PROG: req_data <= `FEC_CMD_PROG; // [R21]
                        fec_pkg::OP_BUF_START: req_data <= `FEC_CMD_BUF;
                        fec_pkg::OP_BUF_DATA: req_data <= data_reg;
                        fec_pkg::OP_BUF_CONFIRM:
                            req_data <= `FEC_CMD_CONFIRM; // [R17]
                        default: req_data <= 16'h0;
                    endcase
                    if (bdone) begin
                        unique case (op)
                            fec_pkg::OP_ERASE, fec_pkg::OP_PROG:
                                state <= fec_pkg::M_W2;
                            fec_pkg::OP_BUF_START: state <= fec_pkg::M_EXT;
                            default: state <= fec_pkg::M_DONE;
                        endcase
                        if (op == fec_pkg::OP_BUF_DATA && !buf_open) begin
                            // First data write fixes the window start [R16]
                            buf_open <= 1'b1;
                            buf_start <= addr_reg;
                            unaligned <= |addr_reg[`FEC_ALIGN_BITS-1:0];
                        end
                        if (op == fec_pkg::OP_BUF_CONFIRM)
                            buf_open <= 1'b0;
                    end
                end
                fec_pkg::M_EXT: begin
                    req <= !bdone;
                    req_rd <= 1'b1;
                    if (bdone) begin
                        extended_buffer_status <= rd_data[7:0];
                        // Retry setup until a buffer is free [R14][R2]
                        if (rd_data[`FEC_EXT_BUF]) begin
                            state <= fec_pkg::M_W2;
                        end else begin
                            state <= fec_pkg::M_W1;
                        end
                    end
                end
                fec_pkg::M_W2: begin
                    req <= !bdone;
                    req_rd <= 1'b0;
                    req_addr <= addr_reg;
                    unique case (op)
                        fec_pkg::OP_ERASE: req_data <= `FEC_CMD_CONFIRM;
                        fec_pkg::OP_BUF_START:
                            req_data <= {8'h00, count_reg}; // [R15]
                        default: req_data <= data_reg;
                    endcase
                    if (bdone) begin
                        state <= fec_pkg::M_DONE;
                        if (op == fec_pkg::OP_BUF_START) begin
                            buf_open <= 1'b0;
                            range_err <= 1'b0;
                        end
                    end
                end
                fec_pkg::M_DONE: begin
                    req <= 1'b0;
                    state <= fec_pkg::M_IDLE;
                end
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    strobe_excl_a: assert property (!(!we_n_o && !oe_n_o)) // [R6]
        else $error("write and read strobes low together");
    write_drives_a: assert property (!we_n_o |-> !flash_dq_oe_n_o) // [R21]
        else $error("write strobe without data drive");
    wb_ack_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not one cycle");
    clear_ready_a: assert property ( // [R4]
        state == fec_pkg::M_W1 && op == fec_pkg::OP_CLEAR
        |-> stat_byte[`FEC_SR_READY])
        else $error("clear issued to a busy device");
    resume_ready_a: assert property ( // [R13]
        state == fec_pkg::M_W1 && op == fec_pkg::OP_RESUME
        |-> stat_byte[`FEC_SR_READY])
        else $error("resume issued before program finished");
    erase_pair_a: assert property ( // [R5]
        state == fec_pkg::M_W1 && op == fec_pkg::OP_ERASE && bdone
        |=> state == fec_pkg::M_W2 && req_addr == $past(addr_reg))
        else $error("erase confirm not following setup");
    setup_retry_a: assert property ( // [R14]
        state == fec_pkg::M_EXT && bdone && !rd_data[`FEC_EXT_BUF]
        |=> state == fec_pkg::M_W1)
        else $error("buffer setup not repeated");
    range_refuse_a: assert property ( // [R15]
        wb_req && wb_we_i && !busy && wb_adr_i == 5'(`FEC_REG_CTRL)
        && wb_dat_i[3:0] == 4'(fec_pkg::OP_BUF_DATA) && buf_open
        && !in_range |=> range_err && !busy)
        else $error("out of window data not refused");
    read_sample_a: assert property ( // [R6]
        $fell(oe_n_o) |-> !oe_n_o [*2] ##1 oe_n_o)
        else $error("read strobe length wrong");

    erase_c: cover property (state == fec_pkg::M_W2
        && op == fec_pkg::OP_ERASE && bdone);
    buf_retry_c: cover property (state == fec_pkg::M_EXT && bdone
        && !rd_data[`FEC_EXT_BUF]);
    wait_done_c: cover property (state == fec_pkg::M_POLL && bdone
        && rd_data[`FEC_SR_READY]);

endmodule

// [hw/fec_consts.svh]
// Purpose: Constants for the flash command controller
// Assumes: 10 MHz clock; classic Wishbone slave for software
// Notes: Command codes without a printed value are plain defaults
`ifndef FEC_CONSTS_SVH
`define FEC_CONSTS_SVH

// Clock period and bus strobe timing
`define FEC_CLK_NS 100
`define FEC_SETUP_NS 100
`define FEC_WE_NS 100
`define FEC_ACC_NS 200
`define FEC_CYC(ns) (((ns) + `FEC_CLK_NS - 1) / `FEC_CLK_NS)

// Register byte offsets
`define FEC_REG_CTRL 4'h0
`define FEC_REG_ADDR 4'h4
`define FEC_REG_DATA 4'h8
`define FEC_REG_COUNT 4'hc
`define FEC_REG_STAT 5'h10

// Device command codes
`define FEC_CMD_CLEAR 16'h0050
`define FEC_CMD_PROG 16'h0040
`define FEC_CMD_PROG_ALT 16'h0010
`define FEC_CMD_ERASE 16'h0020
`define FEC_CMD_CONFIRM 16'h00d0
`define FEC_CMD_SUSPEND 16'h00b0
`define FEC_CMD_RESUME 16'h00d0
`define FEC_CMD_BUF 16'h00e8
`define FEC_CMD_RDSTAT 16'h0070

// Device status and extended status bits
`define FEC_SR_READY 7
`define FEC_SR_SUSP 6
`define FEC_SR_ERASE_ERR 5
`define FEC_SR_PROG_ERR 4
`define FEC_SR_LOWV 3
`define FEC_SR_PROT 1
`define FEC_EXT_BUF 7
`define FEC_ALIGN_BITS 5

`endif

// [hw/fec_pkg.sv]
// Purpose: Types for the flash command controller
// Assumes: Constants live in fec_consts.svh
// Notes: Operation codes are written to the control register
package fec_pkg;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_CLEAR = 4'h1,
        OP_ERASE = 4'h2,
        OP_SUSPEND = 4'h3,
        OP_RESUME = 4'h4,
        OP_PROG = 4'h5,
        OP_BUF_START = 4'h6,
        OP_BUF_DATA = 4'h7,
        OP_BUF_CONFIRM = 4'h8,
        OP_WAIT = 4'h9
    } fec_op_t;

    typedef enum {M_IDLE, M_RSC, M_POLL, M_W1, M_EXT, M_W2, M_DONE}
        fec_main_t;

    typedef enum {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fec_bus_t;

endpackage

// [verification/fec_flash_model.sv]
// Purpose: Behavioural flash device facing the command controller
// Assumes: Pins sampled on clk_i; every operation runs OP_CYC cycles
// Notes: Fault causes come from locked_i and lowv_i, for every block
`timescale 1ns/10ps
module fec_flash_model #(
    parameter int OP_CYC = 60,
    parameter int BUF_WAIT = 2,
    // Address bits inside one erase block
    parameter int BLK_BITS = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Flash pins
    input wire logic [15:0] dq_i,
    input wire logic [23:0] addr_i,
    input wire logic dq_oe_n_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    output logic [15:0] dq_o,
    output logic ready_o,
    // Fault causes
    input wire logic locked_i,
    input wire logic lowv_i
);
    logic [7:0] sr, extended_buffer_status, left, c, f_e, f_p;
    logic [23:0] blk;
    logic [2:0] step;
    logic we_d, ext_rd, erasing, wr;
    int busy, hold, tries;

    assign c = dq_i[7:0];
    // Command taken on the write-enable rising edge
    assign wr = we_n_i && !we_d && !ce_n_i && !dq_oe_n_i;
    assign f_e = lowv_i ? 8'h28 : locked_i ? 8'h22 : 8'h00;
    assign f_p = lowv_i ? 8'h18 : locked_i ? 8'h12 : 8'h00;
    assign ready_o = (busy == 0);

    always_ff @(posedge clk_i) begin
        we_d <= we_n_i;
        if (rst_i) begin
            sr <= 8'h00;
            step <= 3'd0;
            busy <= 0;
            tries <= 0;
            ext_rd <= 1'b0;
            erasing <= 1'b0;
        end else begin
            if (busy != 0)
                busy <= busy - 1;
            if (busy == 1 && !sr[6])
                erasing <= 1'b0;
            if (wr) begin
                ext_rd <= 1'b0;
                case (step)
                3'd1: begin
                    step <= 3'd0;
                    if (c != 8'hd0 || (addr_i >> BLK_BITS) != blk)
                        sr <= sr | 8'h30;
                    else if (f_e != 8'h00)
                        sr <= sr | f_e;
                    else begin
                        busy <= OP_CYC;
                        erasing <= 1'b1;
                    end
                end
                3'd2: begin
                    step <= 3'd0;
                    if (f_p != 8'h00)
                        sr <= sr | f_p;
                    else
                        busy <= OP_CYC;
                end
                3'd3: begin
                    step <= 3'd4;
                    left <= c + 8'h01;
                end
                3'd4: begin
                    left <= left - 8'h01;
                    if (left == 8'h01)
                        step <= 3'd5;
                    if ((addr_i >> BLK_BITS) != blk) begin
                        sr <= sr | 8'h30;
                        step <= 3'd0;
                    end
                end
                3'd5: begin
                    step <= 3'd0;
                    if (c != 8'hd0)
                        sr <= sr | 8'h30;
                    else if (f_p != 8'h00)
                        sr <= sr | f_p;
                    else
                        busy <= OP_CYC;
                end
                default: begin
                    // Setup writes carry the block address
                    blk <= addr_i >> BLK_BITS;
                    case (c)
                    8'h50: if (busy == 0) sr <= sr & 8'h40;
                    8'h20: if (!sr[6]) step <= 3'd1;
                    8'h40, 8'h10: step <= 3'd2;
                    8'hb0: if (erasing && busy > 1) begin
                        hold <= busy;
                        busy <= 0;
                        sr <= sr | 8'h40;
                    end
                    8'hd0: if (sr[6] && busy == 0) begin
                        sr <= sr & 8'hbf;
                        busy <= hold;
                    end
                    8'he8: begin
                        ext_rd <= 1'b1;
                        tries <= tries + 1;
                        // Refused while an error flag is set
                        if ((sr & 8'h30) == 8'h00 && tries >= BUF_WAIT) begin
                            extended_buffer_status <= 8'h80;
                            step <= 3'd3;
                            tries <= 0;
                        end else
                            extended_buffer_status <= 8'h00;
                    end
                    default: ;
                    endcase
                end
                endcase
            end
        end
    end

    // Released bus shows no stale value
    always_ff @(posedge clk_i) begin
        if (rst_i)
            dq_o <= 16'h0000;
        else if (!ce_n_i && !oe_n_i)
            dq_o <= {8'h00, ext_rd ? extended_buffer_status
                : {ready_o, sr[6:0]}};
        else
            dq_o <= ~dq_o;
    end
endmodule

// [verification/tb_fec_ctrl.sv]
// Purpose: Self-checking bench for the flash command controller
// Assumes: Behavioural flash model on the far side
// Notes: Each operation waits for completion through the busy bit
`timescale 1ns/10ps
`include "fec_consts.svh"
module tb_fec_ctrl;
    localparam logic [4:0] R_CTRL = {1'b0, `FEC_REG_CTRL};
    localparam logic [4:0] R_ADDR = {1'b0, `FEC_REG_ADDR};
    localparam logic [4:0] R_DATA = {1'b0, `FEC_REG_DATA};
    localparam logic [4:0] R_CNT = {1'b0, `FEC_REG_COUNT};
    localparam logic [4:0] R_STAT = `FEC_REG_STAT;
    logic clk, rst, cyc, stb, we, ack, ce_n, oe_n, we_n, dq_oe_n, rdy;
    logic locked, lowv;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] dq_w, dq_r;
    logic [23:0] fa;
    int mismatches, checks_done;

    fec_ctrl i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .flash_addr_o(fa),
        .flash_dq_o(dq_w), .flash_dq_oe_n_o(dq_oe_n), .flash_dq_i(dq_r),
        .chip_enable_x_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
        .ready_status_pin_i(rdy));
    fec_flash_model i_flash (.clk_i(clk), .rst_i(rst), .dq_i(dq_w),
        .addr_i(fa),
        .dq_oe_n_i(dq_oe_n), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .dq_o(dq_r), .ready_o(rdy), .locked_i(locked), .lowv_i(lowv));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic test_done;
        $display("Mismatches %0d, checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        $display("Error %0t: run did not finish", $time);
        test_done;
    end

    task automatic chk(input logic [31:0] got, exp, msk);
        checks_done++;
        if ((got & msk) !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got & msk, exp);
        end
    endtask

    // Classic single cycle; hold until ack is sampled high
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            mismatches++;
            $display("Error %0t: no bus answer", $time);
        end
    endtask

    task automatic op(input fec_pkg::fec_op_t o);
        int n;
        bus(1'b1, R_CTRL, {28'h0, o});
        n = 0;
        do begin
            bus(1'b0, R_CTRL, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 300);
        chk(q, 32'h0, 32'h1);
    endtask

    task automatic stat(input logic [31:0] exp, msk);
        bus(1'b0, R_STAT, 32'h0);
        chk(q, exp, msk);
    endtask

    task automatic t_reset;
        stat(32'h00080000, 32'hffffffff);
        bus(1'b0, 5'h14, 32'h0);
        chk(q, 32'h0, 32'hffffffff);
    endtask

    task automatic t_erase;
        bus(1'b1, R_ADDR, 32'h020000);
        op(fec_pkg::OP_ERASE);
        stat(32'h0, 32'h00080000);
        op(fec_pkg::OP_WAIT);
        stat(32'h00080080, 32'h000800ff);
    endtask

    task automatic t_errors;
        logic [7:0] e [4];
        e = '{8'ha2, 8'ha8, 8'h92, 8'h98};
        for (int i = 0; i < 4; i++) begin
            locked <= !i[0];
            lowv <= i[0];
            op(i < 2 ? fec_pkg::OP_ERASE : fec_pkg::OP_PROG);
            op(fec_pkg::OP_WAIT);
            stat({24'h0, e[i]}, 32'hff);
            locked <= 1'b0;
            lowv <= 1'b0;
            op(fec_pkg::OP_PROG);
            op(fec_pkg::OP_WAIT);
            stat({24'h0, e[i]}, 32'hff);
            op(fec_pkg::OP_CLEAR);
            op(fec_pkg::OP_WAIT);
            stat(32'h80, 32'hff);
        end
    endtask

    task automatic t_suspend;
        bus(1'b1, R_ADDR, 32'h020000);
        op(fec_pkg::OP_ERASE);
        op(fec_pkg::OP_SUSPEND);
        op(fec_pkg::OP_WAIT);
        stat(32'h000800c0, 32'h000800ff);
        bus(1'b1, R_ADDR, 32'h040000);
        bus(1'b1, R_DATA, 32'h1234);
        op(fec_pkg::OP_PROG);
        stat(32'h0, 32'h00080000);
        op(fec_pkg::OP_WAIT);
        stat(32'hc0, 32'hff);
        op(fec_pkg::OP_RESUME);
        stat(32'h0, 32'h00080000);
        op(fec_pkg::OP_WAIT);
        stat(32'h80, 32'hff);
    endtask

    task automatic t_buffer;
        bus(1'b1, R_ADDR, 32'h060000);
        bus(1'b1, R_CNT, 32'h1);
        op(fec_pkg::OP_BUF_START);
        stat(32'h8000, 32'h0006ff00);
        bus(1'b1, R_DATA, 32'h00aa);
        op(fec_pkg::OP_BUF_DATA);
        bus(1'b1, R_ADDR, 32'h060001);
        op(fec_pkg::OP_BUF_DATA);
        bus(1'b1, R_ADDR, 32'h060003);
        op(fec_pkg::OP_BUF_DATA);
        stat(32'h00020000, 32'h00020000);
        op(fec_pkg::OP_BUF_CONFIRM);
        op(fec_pkg::OP_WAIT);
        stat(32'h80, 32'hff);
    endtask

    task automatic t_cross;
        bus(1'b1, R_ADDR, 32'h06ffff);
        op(fec_pkg::OP_BUF_START);
        op(fec_pkg::OP_BUF_DATA);
        bus(1'b1, R_ADDR, 32'h070000);
        op(fec_pkg::OP_BUF_DATA);
        op(fec_pkg::OP_WAIT);
        stat(32'h000400b0, 32'h000400ff);
        op(fec_pkg::OP_CLEAR);
        op(fec_pkg::OP_WAIT);
        stat(32'h80, 32'hff);
    endtask

    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 5'h00;
        wdat = 32'h0;
        sel = 4'hf;
        locked = 1'b0;
        lowv = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_erase;
        t_errors;
        t_suspend;
        t_buffer;
        t_cross;
        test_done;
    end
endmodule
